// >>> hw/csr_status_results.sv
// Status flags, channel results and gain configuration registers of the color sensor
//
// Function
// RULE1: saturation flag bit 7, cleared writing one
// RULE2: light interrupt flag bit 4, write-one clears
// RULE3: Z result bytes at 0x94/0x95, read-only
// RULE4: Y result bytes at 0x96/0x97, read-only
// RULE5: first infrared bytes at 0x98/0x99, read-only
// RULE6: channel 3 holds X when select zero
// RULE7: channel 3 holds second infrared when select one
// RULE8: 128x gain needs extension bit and code 11
// RULE9: host writes 000 and 0100 into config2
// RULE10: select bit 3, gain bits 1:0 of config1
// RULE11: interrupt pin low for enabled light flag
// RULE12: clear-on-read option clears flags on status read
// RULE13: reserved bits zero, writing zero keeps flags
// RULE14: results update together, zero after reset
`include "csr_defs.svh"
`timescale 1ns/10ps
`default_nettype none

module csr_status_results #(
  parameter int RESULT_W = 16
) (
  // Clock and reset
  input  wire logic                   core_clk_i,
  input  wire logic                   rst_b_i,
  // Register access from the serial slave
  input  wire logic [`CSR_ADDR_W-1:0] reg_addr_i,
  input  wire logic                   reg_wr_i,
  input  wire csr_pkg::csr_byte_t     reg_wdata_i,
  input  wire logic                   reg_rd_i,
  output var  csr_pkg::csr_byte_t     reg_rdata_o,
  // Front end events and results
  input  wire logic                   sat_event_i,
  input  wire logic                   light_event_i,
  input  wire logic                   conv_done_i,
  input  wire logic [RESULT_W-1:0]    z_value_i,
  input  wire logic [RESULT_W-1:0]    y_value_i,
  input  wire logic [RESULT_W-1:0]    ir1_value_i,
  input  wire logic [RESULT_W-1:0]    x_value_i,
  input  wire logic [RESULT_W-1:0]    ir2_value_i,
  // Configuration to the front end
  output var  csr_pkg::csr_gain_t     gain_o,
  output logic                        channel3_source_select_o,
  // Open-drain interrupt pin, active low
  output logic                        int_pin_o,
  output logic                        int_pin_oe_o
);
  import csr_pkg::*;

  if (RESULT_W != 16) begin : g_width_check
    $error("csr_status_results: RESULT_W must be 16, two bytes per result");
  end

  localparam int NCH = 4;

  csr_byte_t             first_config_register;
  csr_byte_t             second_config_register;
  csr_byte_t             third_config_register;
  csr_byte_t             int_enable;
  logic                  saturation_flag;
  logic                  light_int_flag;
  logic [RESULT_W-1:0]   result [NCH];
  logic [RESULT_W-1:0]   next_result [NCH];
  logic                  flags_wr;
  logic                  flags_rd_clear;
  logic                  next_saturation_flag;
  logic                  next_light_int_flag;
  csr_byte_t             next_rdata;
  csr_gain_t             next_gain;

  assign flags_wr       = reg_wr_i && (reg_addr_i == `CSR_OFS_FLAGS);
  assign flags_rd_clear = reg_rd_i && (reg_addr_i == `CSR_OFS_FLAGS)
                          && third_config_register[`CSR_CLR_ON_READ_BIT]; // [RULE12]

  // Set wins over any clear in the same cycle
  always_comb begin
    next_saturation_flag = saturation_flag;
    next_light_int_flag  = light_int_flag;
    if (flags_rd_clear) begin // [RULE12]
      next_saturation_flag = 1'b0;
      next_light_int_flag  = 1'b0;
    end
    if (flags_wr && reg_wdata_i[`CSR_SAT_BIT]) begin // [RULE1] [RULE13]
      next_saturation_flag = 1'b0;
    end
    if (flags_wr && reg_wdata_i[`CSR_LIGHT_BIT]) begin // [RULE2] [RULE13]
      next_light_int_flag = 1'b0;
    end
    if (sat_event_i) begin // [RULE1]
      next_saturation_flag = 1'b1;
    end
    if (light_event_i) begin // [RULE2]
      next_light_int_flag = 1'b1;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      saturation_flag <= 1'b0;
      light_int_flag  <= 1'b0;
    end else begin
      saturation_flag <= next_saturation_flag;
      light_int_flag  <= next_light_int_flag;
    end
  end

  // Configuration registers, all bits writable
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      first_config_register  <= `CSR_RST_CONFIG1;
      second_config_register <= `CSR_RST_CONFIG2;
      third_config_register  <= `CSR_RST_CONFIG3;
      int_enable             <= `CSR_RST_INT_ENABLE;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        `CSR_OFS_CONFIG1:    first_config_register  <= reg_wdata_i; // [RULE10]
        `CSR_OFS_CONFIG2:    second_config_register <= reg_wdata_i; // [RULE9]
        `CSR_OFS_CONFIG3:    third_config_register  <= reg_wdata_i;
        `CSR_OFS_INT_ENABLE: int_enable             <= reg_wdata_i;
        default: begin
        end
      endcase
    end
  end

  // Channel 3 source is chosen when the result is captured
  always_comb begin
    next_result[0] = z_value_i;   // [RULE3]
    next_result[1] = y_value_i;   // [RULE4]
    next_result[2] = ir1_value_i; // [RULE5]
    next_result[3] = first_config_register[`CSR_CH3_SEL_BIT] ? ir2_value_i // [RULE7]
                                                             : x_value_i;  // [RULE6]
  end

  for (genvar ch = 0; ch < NCH; ch++) begin : g_result
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
        result[ch] <= '0; // [RULE14]
      end else if (conv_done_i) begin
        result[ch] <= next_result[ch]; // [RULE14]
      end
    end
  end

  // Read data; result registers ignore writes
  always_comb begin
    next_rdata = `CSR_RST_ZERO;
    case (reg_addr_i)
      `CSR_OFS_CONFIG1:    next_rdata = first_config_register;
      `CSR_OFS_FLAGS: begin
        next_rdata[`CSR_SAT_BIT]   = saturation_flag; // [RULE13]
        next_rdata[`CSR_LIGHT_BIT] = light_int_flag;
      end
      `CSR_OFS_Z_LOW:      next_rdata = result[0][7:0];  // [RULE3]
      `CSR_OFS_Z_HIGH:     next_rdata = result[0][15:8]; // [RULE3]
      `CSR_OFS_Y_LOW:      next_rdata = result[1][7:0];  // [RULE4]
      `CSR_OFS_Y_HIGH:     next_rdata = result[1][15:8]; // [RULE4]
      `CSR_OFS_IR1_LOW:    next_rdata = result[2][7:0];  // [RULE5]
      `CSR_OFS_IR1_HIGH:   next_rdata = result[2][15:8]; // [RULE5]
      `CSR_OFS_CH3_LOW:    next_rdata = result[3][7:0];  // [RULE6]
      `CSR_OFS_CH3_HIGH:   next_rdata = result[3][15:8]; // [RULE6]
      `CSR_OFS_CONFIG2:    next_rdata = second_config_register;
      `CSR_OFS_CONFIG3:    next_rdata = third_config_register;
      `CSR_OFS_INT_ENABLE: next_rdata = int_enable;
      default:             next_rdata = `CSR_RST_ZERO;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      reg_rdata_o <= `CSR_RST_ZERO;
    end else if (reg_rd_i) begin
      reg_rdata_o <= next_rdata;
    end
  end

  // Gain decode
  always_comb begin
    case (first_config_register[`CSR_GAIN_HI:`CSR_GAIN_LO]) // [RULE10]
      2'h0:    next_gain = CSR_GAIN_1X;
      2'h1:    next_gain = CSR_GAIN_4X;
      2'h2:    next_gain = CSR_GAIN_16X;
      2'h3:    next_gain = CSR_GAIN_64X;
      default: next_gain = CSR_GAIN_1X;
    endcase
    if (second_config_register[`CSR_GAIN_EXT_BIT]
        && first_config_register[`CSR_GAIN_HI:`CSR_GAIN_LO] == `CSR_GAIN_TOP_CODE) begin
      next_gain = CSR_GAIN_128X; // [RULE8]
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      gain_o                   <= CSR_GAIN_1X;
      channel3_source_select_o <= 1'b0;
    end else begin
      gain_o                   <= next_gain;
      channel3_source_select_o <= first_config_register[`CSR_CH3_SEL_BIT]; // [RULE10]
    end
  end

  // Pin is pulled low while an enabled flag stands
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      int_pin_o    <= 1'b0;
      int_pin_oe_o <= 1'b0;
    end else begin
      int_pin_o    <= 1'b0;
      int_pin_oe_o <= (next_light_int_flag && int_enable[`CSR_LIGHT_EN_BIT]) // [RULE11]
                      || (next_saturation_flag && int_enable[`CSR_SAT_EN_BIT]);
    end
  end

endmodule : csr_status_results

`default_nettype wire

// >>> hw/csr_defs.svh
// Register offsets, field positions and reset values of the sensor status block
`ifndef CSR_DEFS_SVH
`define CSR_DEFS_SVH

`define CSR_ADDR_W          8
`define CSR_OFS_CONFIG1     8'h90
`define CSR_OFS_FLAGS       8'h93
`define CSR_OFS_Z_LOW       8'h94
`define CSR_OFS_Z_HIGH      8'h95
`define CSR_OFS_Y_LOW       8'h96
`define CSR_OFS_Y_HIGH      8'h97
`define CSR_OFS_IR1_LOW     8'h98
`define CSR_OFS_IR1_HIGH    8'h99
`define CSR_OFS_CH3_LOW     8'h9a
`define CSR_OFS_CH3_HIGH    8'h9b
`define CSR_OFS_CONFIG2     8'h9f
`define CSR_OFS_CONFIG3     8'hab
`define CSR_OFS_INT_ENABLE  8'hdd

`define CSR_SAT_BIT         7
`define CSR_LIGHT_BIT       4
`define CSR_CH3_SEL_BIT     3
`define CSR_GAIN_HI         1
`define CSR_GAIN_LO         0
`define CSR_GAIN_EXT_BIT    4
`define CSR_CLR_ON_READ_BIT 7
`define CSR_SAT_EN_BIT      7
`define CSR_LIGHT_EN_BIT    4
`define CSR_GAIN_TOP_CODE   2'h3

`define CSR_RST_CONFIG1     8'h00
`define CSR_RST_CONFIG2     8'h04
`define CSR_RST_CONFIG3     8'h0c
`define CSR_RST_INT_ENABLE  8'h00
`define CSR_RST_ZERO        8'h00

`endif

// >>> hw/csr_pkg.sv
// Types shared by the sensor status and result block
package csr_pkg;
  typedef logic [7:0] csr_byte_t;
  typedef enum logic [2:0] {
    CSR_GAIN_1X   = 3'h0,
    CSR_GAIN_4X   = 3'h1,
    CSR_GAIN_16X  = 3'h2,
    CSR_GAIN_64X  = 3'h3,
    CSR_GAIN_128X = 3'h4
  } csr_gain_t;
endpackage : csr_pkg

// >>> verification/csr_checker.sv
// Port assertions for the status and result block
`timescale 1ns/10ps
`default_nettype none
module csr_checker #(parameter int RESULT_W = 16) (
  input wire logic core_clk_i, rst_b_i, reg_wr_i, reg_rd_i, conv_done_i, sat_event_i,
  input wire logic light_event_i, channel3_source_select_o, int_pin_o, int_pin_oe_o,
  input wire logic [7:0] reg_addr_i,
  input wire csr_pkg::csr_byte_t reg_wdata_i, reg_rdata_o,
  input wire logic [RESULT_W-1:0] z_value_i, y_value_i, ir1_value_i, x_value_i, ir2_value_i,
  input wire csr_pkg::csr_gain_t gain_o
);
  import csr_pkg::*;
  logic [1:0] code_q;
  logic       hg_q;
  wire rd93 = reg_rd_i && reg_addr_i == 8'h93;
  wire quiet = !sat_event_i && !light_event_i;
  wire ev_w = sat_event_i || light_event_i;
  // An enable write reaches the pin one cycle later than an event does
  wire en_w = reg_wr_i && reg_addr_i == 8'hdd;
  wire [2:0] exp_gain = (code_q == 2'h3 && hg_q) ? 3'h4 : {1'b0, code_q};
  // Shadow of the gain settings written by the host
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      code_q <= 2'h0;
      hg_q   <= 1'b0;
    end else if (reg_wr_i && reg_addr_i == 8'h90) begin
      code_q <= reg_wdata_i[1:0];
    end else if (reg_wr_i && reg_addr_i == 8'h9f) begin
      hg_q <= reg_wdata_i[4];
    end
  end
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);
  property p_ch3_x;
    conv_done_i && !channel3_source_select_o ##2 (reg_rd_i && reg_addr_i == 8'h9a && !conv_done_i)
      |=> reg_rdata_o == 8'($past(x_value_i, 3));
  endproperty
  a_ch3_x: assert property (p_ch3_x) else $error("channel 3 low byte is not X");
  property p_ch3_ir;
    conv_done_i && channel3_source_select_o ##2 (reg_rd_i && reg_addr_i == 8'h9a && !conv_done_i)
      |=> reg_rdata_o == 8'($past(ir2_value_i, 3));
  endproperty
  a_ch3_ir: assert property (p_ch3_ir) else $error("channel 3 low byte is not IR2");
  property p_gain;
    reg_wr_i && (reg_addr_i == 8'h90 || reg_addr_i == 8'h9f) |=> !reg_wr_i |-> ##1
      gain_o == csr_gain_t'(exp_gain);
  endproperty
  a_gain: assert property (p_gain) else $error("gain output wrong");
  property p_clear;
    reg_wr_i && reg_addr_i == 8'h93 && quiet ##1 quiet ##1 rd93 && quiet
      |=> (reg_rdata_o & $past(reg_wdata_i, 3)) == 8'h00;
  endproperty
  a_clear: assert property (p_clear) else $error("written flag not cleared");
  property p_resv;
    rd93 |=> reg_rdata_o[6:5] == 2'h0 && reg_rdata_o[3:0] == 4'h0;
  endproperty
  a_resv: assert property (p_resv) else $error("reserved status bits set");
  property p_int_rise;
    $rose(int_pin_oe_o) |-> ($past(ev_w) || $past(en_w, 2)) && int_pin_o == 1'b0;
  endproperty
  a_int_rise: assert property (p_int_rise) else $error("pin driven without cause");
  property p_sat;
    sat_event_i ##2 rd93 |=> reg_rdata_o[7];
  endproperty
  a_sat: assert property (p_sat) else $error("saturation flag missing");
  property p_light;
    light_event_i ##2 rd93 |=> reg_rdata_o[4];
  endproperty
  a_light: assert property (p_light) else $error("light flag missing");
endmodule : csr_checker
bind csr_status_results csr_checker #(.RESULT_W(RESULT_W)) u_chk (
  .core_clk_i               (core_clk_i),
  .rst_b_i                  (rst_b_i),
  .reg_wr_i                 (reg_wr_i),
  .reg_rd_i                 (reg_rd_i),
  .conv_done_i              (conv_done_i),
  .sat_event_i              (sat_event_i),
  .light_event_i            (light_event_i),
  .channel3_source_select_o (channel3_source_select_o),
  .int_pin_o                (int_pin_o),
  .int_pin_oe_o             (int_pin_oe_o),
  .reg_addr_i               (reg_addr_i),
  .reg_wdata_i              (reg_wdata_i),
  .reg_rdata_o              (reg_rdata_o),
  .z_value_i                (z_value_i),
  .y_value_i                (y_value_i),
  .ir1_value_i              (ir1_value_i),
  .x_value_i                (x_value_i),
  .ir2_value_i              (ir2_value_i),
  .gain_o                   (gain_o)
);
`default_nettype wire

// >>> verification/csr_host_model.sv
// Host model issuing register reads and writes
`timescale 1ns/10ps
`default_nettype none
module csr_host_model (
  input  wire logic               clk_i,
  input  wire csr_pkg::csr_byte_t rdata_i,
  output logic [7:0]              addr_o,
  output logic                    wr_o,
  output logic                    rd_o,
  output csr_pkg::csr_byte_t      wdata_o
);
  import csr_pkg::*;
  initial begin
    addr_o  = 8'h00;
    wr_o    = 1'b0;
    rd_o    = 1'b0;
    wdata_o = 8'h00;
  end
  task automatic access(input logic w, input logic [7:0] a, input csr_byte_t d,
                        output csr_byte_t q);
    @(posedge clk_i) #1;
    addr_o  = a;
    wdata_o = d;
    wr_o    = w;
    rd_o    = !w;
    @(posedge clk_i) #1;
    q       = rdata_i;
    wr_o    = 1'b0;
    rd_o    = 1'b0;
    addr_o  = ~a;
    wdata_o = ~d;
  endtask : access
  task automatic gain_extension_config(input logic hg);
    csr_byte_t q;
    access(1'b1, 8'h9f, {3'h0, hg, 4'h4}, q);
  endtask : gain_extension_config
endmodule : csr_host_model
`default_nettype wire

// >>> verification/tb.sv
// Self-checking bench for the status and result block
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin errors++; \
  $display("ERROR t=%0t got %h exp %h", $time, g, e); end end
module tb;
  import csr_pkg::*;
  logic core_clk = 0, rst_b = 0, sat = 0, light = 0, conv = 0, wr, rd, sel, pin, pin_oe;
  logic [15:0] val[5] = '{16'h1234, 16'h5678, 16'h9abc, 16'hdef0, 16'h0f1e};
  logic [7:0] addr;
  csr_byte_t wdata, rdata, q;
  csr_gain_t gain;
  int errors = 0, check_count = 0, cyc = 0;
  always #5 core_clk = ~core_clk;
  csr_host_model host (.clk_i(core_clk), .rdata_i(rdata), .addr_o(addr), .wr_o(wr),
    .rd_o(rd), .wdata_o(wdata));
  csr_status_results dut (.core_clk_i(core_clk), .rst_b_i(rst_b), .reg_addr_i(addr),
    .reg_wr_i(wr), .reg_wdata_i(wdata), .reg_rd_i(rd), .reg_rdata_o(rdata), .sat_event_i(sat),
    .light_event_i(light), .conv_done_i(conv), .z_value_i(val[0]), .y_value_i(val[1]),
    .ir1_value_i(val[2]), .x_value_i(val[3]), .ir2_value_i(val[4]), .gain_o(gain),
    .channel3_source_select_o(sel), .int_pin_o(pin), .int_pin_oe_o(pin_oe));
  task automatic rd_chk(input logic [7:0] a, input csr_byte_t e);
    host.access(1'b0, a, 8'h00, q);
    `CHK(q, e)
  endtask : rd_chk
  task automatic pulse(ref logic s);
    @(posedge core_clk) #1 s = 1'b1;
    @(posedge core_clk) #1 s = 1'b0;
  endtask : pulse
  task automatic t_reset;
    for (int i = 8'h93; i <= 8'h9b; i++) rd_chk(8'(i), 8'h00);
    rd_chk(8'h9f, 8'h04);
    rd_chk(8'h80, 8'h00);
    rd_chk(8'h90, 8'h00);
    `CHK(gain, CSR_GAIN_1X)
    `CHK({sel, pin_oe, pin}, 3'b000)
  endtask : t_reset
  task automatic t_results;
    pulse(conv);
    rd_chk(8'h9a, val[3][7:0]);
    host.access(1'b1, 8'h94, 8'hff, q);
    for (int i = 0; i < 4; i++) begin
      rd_chk(8'h94 + 8'(2 * i), val[i][7:0]);
      rd_chk(8'h95 + 8'(2 * i), val[i][15:8]);
    end
    host.access(1'b1, 8'h90, 8'h08, q);
    @(posedge core_clk) #1;
    `CHK(sel, 1'b1)
    pulse(conv);
    rd_chk(8'h9a, val[4][7:0]);
    rd_chk(8'h9b, val[4][15:8]);
  endtask : t_results
  task automatic t_gain;
    for (int h = 0; h < 2; h++) for (int c = 0; c < 4; c++) begin
      host.gain_extension_config(h[0]);
      host.access(1'b1, 8'h90, 8'(c), q);
      @(posedge core_clk) #1;
      `CHK(gain, csr_gain_t'((h == 1 && c == 3) ? 4 : c))
    end
  endtask : t_gain
  task automatic t_flags;
    host.access(1'b1, 8'hdd, 8'h10, q);
    pulse(light);
    `CHK({pin_oe, pin}, 2'b10)
    rd_chk(8'h93, 8'h10);
    host.access(1'b1, 8'h93, 8'h6f, q);
    rd_chk(8'h93, 8'h10);
    host.access(1'b1, 8'h93, 8'h10, q);
    rd_chk(8'h93, 8'h00);
    `CHK(pin_oe, 1'b0)
    pulse(sat);
    rd_chk(8'h93, 8'h80);
    host.access(1'b1, 8'h93, 8'h80, q);
    rd_chk(8'h93, 8'h00);
    host.access(1'b1, 8'hab, 8'h8c, q);
    pulse(sat);
    rd_chk(8'h93, 8'h80);
    rd_chk(8'h93, 8'h00);
  endtask : t_flags
  task automatic tally_and_finish;
    if (errors == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 3000) begin
      errors++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (20) @(posedge core_clk);
    #1 rst_b = 1'b1;
    t_reset();
    t_results();
    t_gain();
    t_flags();
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire
